// ==== sim/cable_echo_test_regs_props.sv ====
// Checker: bus timing and configuration behaviour
`timescale 1ns/1ns
module cable_echo_test_regs_props
   import cable_echo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic [3:0] avs_byteenable,
   input wire logic [ADDR_W+1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire echo_cfg_t echoCfg
);
   wire logic [9:0] idx = avs_address[11:2];
   wire logic cfgWr = clkEn && avs_write && avs_waitrequest && avs_byteenable[1:0] == 2'h3 &&
      idx == IDX_CONFIG;
   wire logic [2:0] avg = avs_writedata[9:7];
   wire logic done = avs_read && !avs_waitrequest;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_WAIT: assert property (clkEn && (avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
      else $error("no answer");
   AST_RST: assert property ($rose(rst_b) |-> echoCfg == CFG_RESET)
      else $error("bad reset value");
   AST_SKIP: assert property (cfgWr |=> echoCfg[12] == $past(avs_writedata[12]))
      else $error("bad skip bit");
   AST_FIELDS: assert property (cfgWr |=> {echoCfg[11:10], echoCfg[6:0]} ==
      $past({avs_writedata[11:10], avs_writedata[6:0]})) else $error("bad fields");
   AST_AVG: assert property (cfgWr && avg != AVG_RESERVED |=> echoCfg[9:7] == $past(avg))
      else $error("bad average");
   AST_AVG_RSV: assert property (cfgWr && avg == AVG_RESERVED |=> $stable(echoCfg[9:7]))
      else $error("reserved code taken");
   AST_READBACK: assert property (done && idx == IDX_CONFIG |-> avs_readdata ==
      {19'h00000, echoCfg}) else $error("bad readback");
   AST_UNMAPPED: assert property (done && idx[9] |-> avs_response == 2'h3 &&
      avs_readdata == ZERO32) else $error("bad unmapped answer");
   cover property (cfgWr && avg == AVG_RESERVED);
   cover property (done && idx == IDX_PEAKS_C01);
   cover property (done && idx[9]);
endmodule : cable_echo_test_regs_props

bind cable_echo_test_regs cable_echo_test_regs_props props_i (.sys_clk(sys_clk), .rst_b(rst_b),
   .clkEn(clkEn), .avs_byteenable(avs_byteenable),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .echoCfg(echoCfg));

// ==== sim/cable_echo_test_regs_tb.sv ====
// Testbench: self-checking scenarios for the echo test registers
`timescale 1ns/1ns
module cable_echo_test_regs_tb
   import cable_echo_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W+1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic [3:0] lag = 4'h0;
   logic [7:0] base = 8'h00;
   peak_result_t testResult;
   echo_cfg_t echoCfg;
   logic testStart;
   logic [DATA_W-1:0] rd;
   logic [1:0] rsp;
   int fails = 0;
   int cmp_count = 0;
   cable_echo_test_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .testResult(testResult), .echoCfg(echoCfg), .testStart(testStart));
   echo_cable_model cable (.sys_clk(sys_clk), .rst_b(rst_b), .testStart(testStart),
      .lag(lag), .base(base), .testResult(testResult));
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic close_out();
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic give_up(input logic bad);
      if (bad) begin
         fails++;
         close_out();
      end
   endtask : give_up
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] idx, input logic [15:0] wd);
      int n = 0;
      @(posedge sys_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {16'h0000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      give_up(avs_waitrequest !== 1'b0);
   endtask : bus
   task automatic reset_values();
      bus(1'b0, IDX_CONFIG, 16'h0000);
      check(rd, 32'h00000752);
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, 10'(IDX_PEAKS_FIRST + k), 16'h0000);
         check(rd, ZERO32);
      end
   endtask : reset_values
   task automatic config_fields();
      bus(1'b1, IDX_CONFIG, 16'hFFFF);
      bus(1'b0, IDX_CONFIG, 16'h0000);
      check(rd, 32'h00001F7F);
      for (int c = 0; c < 7; c++) begin
         bus(1'b1, IDX_CONFIG, 16'(c << 7));
         bus(1'b0, IDX_CONFIG, 16'h0000);
         check(rd, 32'(c << 7));
      end
      bus(1'b1, IDX_CONFIG, 16'h0395);
      bus(1'b0, IDX_CONFIG, 16'h0000);
      check(rd, 32'h00000315);
   endtask : config_fields
   task automatic run_test(input logic [3:0] l, input logic [7:0] b);
      lag <= l;
      base <= b;
      bus(1'b1, IDX_CONTROL, 16'h0001);
      for (int n = 0; n < 40 && testResult.valid !== 1'b1; n++) @(posedge sys_clk);
      give_up(testResult.valid !== 1'b1);
      bus(1'b0, IDX_STATUS, 16'h0000);
      check(rd, 32'(1 << STS_DONE_BIT));
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, 10'(IDX_PEAKS_FIRST + k), 16'h0000);
         check(rd, {16'h0000, b + 8'(2 * k + 1), b + 8'(2 * k)});
      end
   endtask : run_test
   task automatic read_only();
      bus(1'b1, IDX_PEAKS_A4_B0, 16'hFFFF);
      bus(1'b0, IDX_PEAKS_A4_B0, 16'h0000);
      check(rd, {16'h0000, base + 8'h05, base + 8'h04});
      bus(1'b0, 10'h3F0, 16'h0000);
      check(32'(rsp), 32'h00000003);
      check(rd, ZERO32);
   endtask : read_only
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      reset_values();
      config_fields();
      run_test(4'h0, 8'h10);
      run_test(4'h9, 8'hA0);
      read_only();
      close_out();
   end
endmodule : cable_echo_test_regs_tb

// ==== sim/echo_cable_model.sv ====
// Partner: measurement side answering a start with one burst of peaks
`timescale 1ns/1ns
module echo_cable_model
   import cable_echo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic testStart,
   input wire logic [3:0] lag,
   input wire logic [7:0] base,
   output peak_result_t testResult
);
   logic [4:0] countReg;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         countReg <= 5'h00;
         testResult <= '0;
      end else begin
         testResult.valid <= 1'b0;
         testResult.peaks <= ~testResult.peaks;
         if (testStart) begin
            countReg <= {1'b0, lag} + 5'h01;
         end else if (countReg == 5'h01) begin
            countReg <= 5'h00;
            testResult.valid <= 1'b1;
            for (int i = 0; i < PEAK_N; i++) begin
               testResult.peaks[i] <= base + 8'(i);
            end
         end else if (countReg != 5'h00) begin
            countReg <= countReg - 5'h01;
         end
      end
   end
endmodule : echo_cable_model

// ==== verilog/cable_echo_pkg.sv ====
// Package: offsets, fields, reset values and carrier types for the cable echo test registers
package cable_echo_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int PEAK_W = 8;
   localparam int PEAK_N = 12;
   // Register indices as printed; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_CONFIG = 10'h180;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_A01 = 10'h190;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_A23 = 10'h191;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_A4_B0 = 10'h192;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_B12 = 10'h193;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_B34 = 10'h194;
   localparam logic [ADDR_W-1:0] IDX_PEAKS_C01 = 10'h195;
   localparam int IDX_PEAKS_FIRST = 10'h190;
   // Own registers: test control and status
   localparam logic [ADDR_W-1:0] IDX_CONTROL = 10'h1A0;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 10'h1A1;
   localparam int CTL_START_BIT = 0;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_DONE_BIT = 1;
   // Configuration fields
   localparam int SKIP_CD_BIT = 12;
   localparam int CROSS_OFF_BIT = 11;
   localparam int LINK_CHK_BIT = 10;
   localparam int AVG_HI = 9;
   localparam int AVG_LO = 7;
   localparam int SEG_HI = 6;
   localparam int SEG_LO = 4;
   localparam int CYC_HI = 3;
   localparam int CYC_LO = 0;
   localparam logic [2:0] AVG_RESERVED = 3'h7;
   localparam logic [2:0] AVG_RESET = 3'h6;
   localparam logic [2:0] SEG_RESET = 3'h5;
   localparam logic [3:0] CYC_RESET = 4'h2;
   localparam logic [REG_W-1:0] ZERO16 = 16'h0000;
   localparam logic [DATA_W-1:0] ZERO32 = 32'h00000000;
   localparam logic [PEAK_W-1:0] PEAK_RESET = 8'h00;

   typedef struct packed {
      logic skipPairsCD;
      logic crossListenOff;
      logic linkPulseCheck;
      logic [2:0] echoAverageCount;
      logic [2:0] echoSegmentCount;
      logic [3:0] echoCycleTime;
   } echo_cfg_t;

   localparam echo_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b1, AVG_RESET, SEG_RESET, CYC_RESET};

   typedef struct packed {
      logic valid;
      logic [PEAK_N-1:0][PEAK_W-1:0] peaks;
   } peak_result_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_t;

   // Peaks in order a0..a4, b0..b4, c0, c1; returns the 16-bit word at an index offset
   function automatic logic [REG_W-1:0] peakWord(input logic [PEAK_N-1:0][PEAK_W-1:0] p,
                                                 input int k);
      peakWord = {p[2*k+1], p[2*k]};
   endfunction : peakWord
endpackage : cable_echo_pkg

// ==== verilog/cable_echo_test_regs.sv ====
// Top: Avalon-MM slave for the cable echo test configuration and peak registers
`timescale 1ns/1ns
//
// Contract
// - Config bit 12 set excludes pairs C and D from the test.
// - Config bit 11 set listens only on the transmitting pair.
// - Config bit 10, reset one, checks link pulses during silence.
// - Bits 9:7 pick averaging count, 1 to 64 cycles, reset code 110.
// - Averaging code 111 writes ignored; field keeps its previous value.
// - Bits 6:4 set segment count, reset 101.
// - Bits 3:0 set cycle time in microseconds, reset 010.
// - Peak fields are 8-bit read-only, reset zero, unchanged by writes.
// - Pair A peaks at 0x190, 0x191 and low byte of 0x192.
// - Pair B peaks: high byte 0x192, then 0x193 and 0x194.
// - Pair C peaks 0 and 1 at 0x195 low and high.
// - Config bits 15:13 read zero, writes ignored.
module cable_echo_test_regs
   import cable_echo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic [ADDR_W+1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input peak_result_t testResult,
   output echo_cfg_t echoCfg,
   output logic testStart
);
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   bus_state_t busState;
   logic [ADDR_W-1:0] idx;
   logic lowLanes;
   logic cfgWr;
   logic [REG_W-1:0] cfgWord;
   logic [PEAK_N-1:0][PEAK_W-1:0] peaks;
   logic busy_reg;
   logic done_reg;
   logic startReq;
   logic [REG_W-1:0] rdWord;
   logic hit;
   logic [DATA_W-1:0] readdata_reg;
   logic [1:0] response_reg;

   assign idx = avs_address[ADDR_W+1:2];
   assign lowLanes = avs_byteenable[0] && avs_byteenable[1];

   // Address decode for reads
   always_comb begin
      hit = 1'b1;
      rdWord = ZERO16;
      if (idx == IDX_CONFIG) begin
         rdWord = cfgWord;
      end else if (idx == IDX_PEAKS_A01) begin
         rdWord = peakWord(peaks, 0);
      end else if (idx == IDX_PEAKS_A23) begin
         rdWord = peakWord(peaks, 1);
      end else if (idx == IDX_PEAKS_A4_B0) begin
         rdWord = peakWord(peaks, 2);
      end else if (idx == IDX_PEAKS_B12) begin
         rdWord = peakWord(peaks, 3);
      end else if (idx == IDX_PEAKS_B34) begin
         rdWord = peakWord(peaks, 4);
      end else if (idx == IDX_PEAKS_C01) begin
         rdWord = peakWord(peaks, 5);
      end else if (idx == IDX_CONTROL) begin
         rdWord = ZERO16;
      end else if (idx == IDX_STATUS) begin
         rdWord = ZERO16;
         rdWord[STS_BUSY_BIT] = busy_reg;
         rdWord[STS_DONE_BIT] = done_reg;
      end else begin
         hit = 1'b0;
      end
   end

   // Request accepted in IDLE, answered one cycle later
   assign avs_waitrequest = (busState == BUS_IDLE);
   assign cfgWr = clkEn && (busState == BUS_IDLE) && avs_write && lowLanes
                  && (idx == IDX_CONFIG);
   assign startReq = clkEn && (busState == BUS_IDLE) && avs_write && avs_byteenable[0]
                     && (idx == IDX_CONTROL) && avs_writedata[CTL_START_BIT];

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busState <= BUS_IDLE;
      end else if (clkEn) begin
         case (busState)
            BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  busState <= BUS_ANSWER;
               end
            end
            BUS_ANSWER: begin
               busState <= BUS_IDLE;
            end
            default: begin
               busState <= BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         readdata_reg <= ZERO32;
         response_reg <= RESP_OK;
      end else if (clkEn && busState == BUS_IDLE && (avs_read || avs_write)) begin
         readdata_reg <= avs_read ? {16'h0000, rdWord} : ZERO32;
         response_reg <= hit ? RESP_OK : RESP_DECERR;
      end
   end

   // Test start pulse and busy/done status; completion wins over a new start in busy/done; testStart follows a start with busy_reg clear by one cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         testStart <= 1'b0;
      end else if (clkEn) begin
         testStart <= startReq && !busy_reg;
         if (testResult.valid) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end else if (startReq && !busy_reg) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
         end
      end
   end

   echo_config_reg uConfig (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .wrEn(cfgWr),
      .wrData(avs_writedata[REG_W-1:0]),
      .cfg(echoCfg),
      .rdWord(cfgWord)
   );

   // Peaks have no write path from the bus
   echo_peak_store uPeaks (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .result(testResult),
      .peaks(peaks)
   );

   assign avs_readdata = readdata_reg;
   assign avs_response = response_reg;
endmodule : cable_echo_test_regs

// ==== verilog/echo_config_reg.sv ====
// Configuration register with reserved-code filtering
`timescale 1ns/1ns
module echo_config_reg
   import cable_echo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic wrEn,
   input wire logic [REG_W-1:0] wrData,
   output echo_cfg_t cfg,
   output logic [REG_W-1:0] rdWord
);
   echo_cfg_t cfg_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg <= CFG_RESET;
      end else if (clkEn && wrEn) begin
         cfg_reg.skipPairsCD <= wrData[SKIP_CD_BIT];
         cfg_reg.crossListenOff <= wrData[CROSS_OFF_BIT];
         cfg_reg.linkPulseCheck <= wrData[LINK_CHK_BIT];
         if (wrData[AVG_HI:AVG_LO] != AVG_RESERVED) begin
            cfg_reg.echoAverageCount <= wrData[AVG_HI:AVG_LO];
         end
         cfg_reg.echoSegmentCount <= wrData[SEG_HI:SEG_LO];
         cfg_reg.echoCycleTime <= wrData[CYC_HI:CYC_LO];
      end
   end

   assign cfg = cfg_reg;
   // Upper bits read zero
   assign rdWord = {3'h0, cfg_reg};
endmodule : echo_config_reg

// ==== verilog/echo_peak_store.sv ====
// Peak location store, loaded in one step at test completion
`timescale 1ns/1ns
module echo_peak_store
   import cable_echo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input peak_result_t result,
   output logic [PEAK_N-1:0][PEAK_W-1:0] peaks
);
   logic [PEAK_N-1:0][PEAK_W-1:0] peaks_reg;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < PEAK_N; i++) begin
            peaks_reg[i] <= PEAK_RESET;
         end
      end else if (clkEn && result.valid) begin
         peaks_reg <= result.peaks;
      end
   end

   assign peaks = peaks_reg;
endmodule : echo_peak_store
